// ==== verilog/rpb_pkg.sv ====
`default_nettype none
package rpb_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int DATA_W   = 16;
  localparam int ADDR_W   = 4;
  localparam int FLD_W    = 5;
  localparam int NUM_PINS = 32;
  localparam int NUM_FN   = 32;
  localparam int NUM_OUT  = 12;
  localparam int NUM_REGS = 9;
  localparam int NUM_FLDS = 16;

  // ****************************************
  // register indexes on the plain port
  // ****************************************
  localparam logic [ADDR_W-1:0] IDX_SPI1_SEL     = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_SPI2_CLK_DAT = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_SPI2_SEL     = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_OUT_BASE     = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_LAST         = 4'h8;

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam int LO_POS = 0;
  localparam int HI_POS = 8;
  localparam logic [FLD_W-1:0] IN_RST  = 5'h1f;
  localparam logic [FLD_W-1:0] OUT_RST = 5'h00;
  localparam logic [FLD_W-1:0] FN_NONE = 5'h00;

  // field slots: four input fields, then pin 0..11 output fields
  localparam int F_P1_SEL   = 0;
  localparam int F_P2_DAT   = 1;
  localparam int F_P2_CLK   = 2;
  localparam int F_P2_SEL   = 3;
  localparam int F_OUT_BASE = 4;

  function automatic logic [ADDR_W-1:0] fld_reg(input int k);
    logic [ADDR_W-1:0] r;
    r = 4'h0;
    if (k == F_P1_SEL) begin
      r = IDX_SPI1_SEL;
    end else if (k == F_P2_DAT || k == F_P2_CLK) begin
      r = IDX_SPI2_CLK_DAT;
    end else if (k == F_P2_SEL) begin
      r = IDX_SPI2_SEL;
    end else begin
      r = IDX_OUT_BASE + ADDR_W'((k - F_OUT_BASE) / 2);
    end
    return r;
  endfunction

  function automatic int fld_pos(input int k);
    int p;
    p = LO_POS;
    if (k == F_P2_CLK || (k >= F_OUT_BASE && ((k - F_OUT_BASE) % 2) == 1)) begin
      p = HI_POS;
    end
    return p;
  endfunction

  function automatic logic [FLD_W-1:0] fld_rst(input int k);
    return (k < F_OUT_BASE) ? IN_RST : OUT_RST;
  endfunction

  typedef struct packed {
    logic port1_slave_select_in;
    logic port2_serial_clock_in;
    logic port2_serial_data_in;
    logic port2_slave_select_in;
  } rpb_spi_in_t;

endpackage
`default_nettype wire

// ==== verilog/rpb_field_reg.sv ====
`timescale 1ns/1ps
`default_nettype none
module rpb_field_reg #(
  parameter logic [rpb_pkg::ADDR_W-1:0] REG_IDX = 4'h0,
  parameter int                         POS     = 0,
  parameter logic [rpb_pkg::FLD_W-1:0]  RST     = 5'h00
) (
  input  wire logic                        clk_i,
  input  wire logic                        resetn_i,
  input  wire logic                        wr_i,
  input  wire logic [rpb_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [rpb_pkg::DATA_W-1:0]  wdata_i,
  output logic      [rpb_pkg::FLD_W-1:0]   field_o
);
  import rpb_pkg::*;

  wire                   hit;
  wire [FLD_W-1:0]       next_field;

  // only the five implemented bits are taken; the rest of the word is dropped
  assign hit        = wr_i && (addr_i == REG_IDX);
  assign next_field = hit ? wdata_i[POS +: FLD_W] : field_o;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      field_o <= RST;
    end else begin
      field_o <= next_field;
    end
  end

endmodule
`default_nettype wire

// ==== verilog/rpb_pin_pick.sv ====
`timescale 1ns/1ps
`default_nettype none
module rpb_pin_pick (
  input  wire logic                          clk_i,
  input  wire logic                          resetn_i,
  input  wire logic [rpb_pkg::NUM_PINS-1:0]  vec_i,
  input  wire logic [rpb_pkg::FLD_W-1:0]     sel_i,
  output logic                               bit_o
);
  import rpb_pkg::*;

  wire picked;

  // registered so every routed signal leaves on a flop edge
  assign picked = vec_i[sel_i];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_o <= 1'b0;
    end else begin
      bit_o <= picked;
    end
  end

endmodule
`default_nettype wire

// ==== verilog/rpb_routing_bank.sv ====
// Behaviour
// [RULE1] bits 4-0 pick port1 slave-select source pin
// [RULE2] bits 12-8 pick port2 clock source pin
// [RULE3] bits 4-0 pick port2 data source pin
// [RULE4] bits 4-0 pick port2 slave-select source pin
// [RULE5] unimplemented bits ignore writes, read zero
// [RULE6] reset: input fields ones, output fields zero
// [RULE7] output word 0 routes pins 0 and 1
// [RULE8] output word 1 routes pins 2 and 3
// [RULE9] output word 2 routes pins 4 and 5
// [RULE10] output word 3 routes pins 6 and 7
// [RULE11] output word 4 routes pins 8 and 9
// [RULE12] output word 5 routes pins 10 and 11
// [RULE13] field value names the driving peripheral function
// [RULE14] plain storage, routing follows next edge; the pin pickers add a flop, so routed outputs change one edge after the field
`timescale 1ns/1ps
`default_nettype none
module rpb_routing_bank (
  input  wire logic                          clk_i,
  input  wire logic                          resetn_i,
  input  wire logic [rpb_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [rpb_pkg::DATA_W-1:0]    wdata_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [rpb_pkg::DATA_W-1:0]    rdata_o,
  input  wire logic [rpb_pkg::NUM_PINS-1:0]  remappable_pin_in_i,
  input  wire logic [rpb_pkg::NUM_FN-1:0]    periph_fn_out_i,
  output rpb_pkg::rpb_spi_in_t               spi_in_o,
  output logic      [rpb_pkg::NUM_OUT-1:0]   remappable_pin_out_o,
  output logic      [rpb_pkg::NUM_OUT-1:0]   remappable_pin_fn_en_o
);
  import rpb_pkg::*;

  // ****************************************
  // routing fields
  // ****************************************
  logic [FLD_W-1:0] fld [NUM_FLDS];

  genvar k;
  generate
    for (k = 0; k < NUM_FLDS; k++) begin : g_fld
      // one field per slot; writes touch only the addressed word
      rpb_field_reg #(
        .REG_IDX (fld_reg(k)),
        .POS     (fld_pos(k)),
        .RST     (fld_rst(k))
      ) u_fld (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .wr_i     (wr_i),
        .addr_i   (addr_i),
        .wdata_i  (wdata_i),
        .field_o  (fld[k])
      ); // [RULE6] [RULE14]
    end
  endgenerate

  wire [FLD_W-1:0] port1_select_source_field;
  wire [FLD_W-1:0] port2_clock_source_field;
  wire [FLD_W-1:0] port2_data_source_field;
  wire [FLD_W-1:0] port2_select_source_field;

  assign port1_select_source_field = fld[F_P1_SEL];
  assign port2_clock_source_field  = fld[F_P2_CLK];
  assign port2_data_source_field   = fld[F_P2_DAT];
  assign port2_select_source_field = fld[F_P2_SEL];

  // ****************************************
  // read-back words
  // ****************************************
  wire [DATA_W-1:0] reg_word [NUM_REGS];

  // single-field words keep the whole upper byte at zero
  assign reg_word[IDX_SPI1_SEL]     = {8'h00, 3'h0, port1_select_source_field}; // [RULE1] [RULE5]
  assign reg_word[IDX_SPI2_CLK_DAT] = {3'h0, port2_clock_source_field,
                                       3'h0, port2_data_source_field};        // [RULE2] [RULE3] [RULE5]
  assign reg_word[IDX_SPI2_SEL]     = {8'h00, 3'h0, port2_select_source_field}; // [RULE4] [RULE5]

  genvar j;
  generate
    for (j = 0; j < NUM_OUT / 2; j++) begin : g_oword
      assign reg_word[IDX_OUT_BASE + j] = {3'h0, fld[F_OUT_BASE + 2*j + 1],
                                           3'h0, fld[F_OUT_BASE + 2*j]}; // [RULE5]
    end
  endgenerate

  wire              rd_hit;
  wire [DATA_W-1:0] next_rdata;

  // unmapped reads answer zero; data only in the cycle after the strobe
  assign rd_hit     = rd_i && (addr_i <= IDX_LAST);
  assign next_rdata = rd_hit ? reg_word[addr_i] : 16'h0000;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // ****************************************
  // input routing to the spi ports
  // ****************************************
  // one flop of delay from pin to peripheral; traded for registered outputs
  rpb_pin_pick u_p1_sel (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .vec_i    (remappable_pin_in_i),
    .sel_i    (port1_select_source_field),
    .bit_o    (spi_in_o.port1_slave_select_in)
  ); // [RULE1]

  rpb_pin_pick u_p2_clk (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .vec_i    (remappable_pin_in_i),
    .sel_i    (port2_clock_source_field),
    .bit_o    (spi_in_o.port2_serial_clock_in)
  ); // [RULE2]

  rpb_pin_pick u_p2_dat (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .vec_i    (remappable_pin_in_i),
    .sel_i    (port2_data_source_field),
    .bit_o    (spi_in_o.port2_serial_data_in)
  ); // [RULE3]

  rpb_pin_pick u_p2_sel (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .vec_i    (remappable_pin_in_i),
    .sel_i    (port2_select_source_field),
    .bit_o    (spi_in_o.port2_slave_select_in)
  ); // [RULE4]

  // ****************************************
  // output routing to remappable pins 0..11
  // ****************************************
  logic [NUM_OUT-1:0] fn_en;
  wire  [NUM_OUT-1:0] next_fn_en;

  genvar p;
  generate
    for (p = 0; p < NUM_OUT; p++) begin : g_pin
      // function code indexes the peripheral output bus directly
      rpb_pin_pick u_pick (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .vec_i    (periph_fn_out_i),
        .sel_i    (fld[F_OUT_BASE + p]),
        .bit_o    (remappable_pin_out_o[p])
      ); // [RULE7] [RULE8] [RULE9] [RULE10] [RULE11] [RULE12] [RULE13]
      // code zero leaves the pin to its port latch
      assign next_fn_en[p] = (fld[F_OUT_BASE + p] != FN_NONE); // [RULE13]
    end
  endgenerate

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fn_en <= '0;
    end else begin
      fn_en <= next_fn_en;
    end
  end

  assign remappable_pin_fn_en_o = fn_en;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  wire pick_p1   = remappable_pin_in_i[port1_select_source_field];
  wire pick_p2c  = remappable_pin_in_i[port2_clock_source_field];
  wire pick_p2d  = remappable_pin_in_i[port2_data_source_field];
  wire pick_p2s  = remappable_pin_in_i[port2_select_source_field];
  wire pick_pin0 = periph_fn_out_i[fld[F_OUT_BASE]];
  wire pick_pin3 = periph_fn_out_i[fld[F_OUT_BASE + 3]];
  wire pick_pin11 = periph_fn_out_i[fld[F_OUT_BASE + 11]];
  wire pick_pin1  = periph_fn_out_i[fld[F_OUT_BASE + 1]];
  wire pick_pin2  = periph_fn_out_i[fld[F_OUT_BASE + 2]];
  wire pick_pin4  = periph_fn_out_i[fld[F_OUT_BASE + 4]];
  wire pick_pin5  = periph_fn_out_i[fld[F_OUT_BASE + 5]];
  wire pick_pin6  = periph_fn_out_i[fld[F_OUT_BASE + 6]];
  wire pick_pin7  = periph_fn_out_i[fld[F_OUT_BASE + 7]];
  wire pick_pin8  = periph_fn_out_i[fld[F_OUT_BASE + 8]];
  wire pick_pin9  = periph_fn_out_i[fld[F_OUT_BASE + 9]];
  wire pick_pin10 = periph_fn_out_i[fld[F_OUT_BASE + 10]];

  p1_route_a: assert property (spi_in_o.port1_slave_select_in == $past(pick_p1)) // [RULE1]
    else $error("port1 select not routed from chosen pin");

  p2_clk_a: assert property ( // [RULE2]
    wr_i && addr_i == IDX_SPI2_CLK_DAT |=> port2_clock_source_field == $past(wdata_i[12:8]))
    else $error("port2 clock field not loaded from bits 12-8");

  p2_data_a: assert property ( // [RULE3]
    spi_in_o.port2_serial_data_in == $past(pick_p2d)
    && spi_in_o.port2_serial_clock_in == $past(pick_p2c))
    else $error("port2 clock or data not routed from chosen pin");

  p2_sel_a: assert property ( // [RULE4]
    wr_i && addr_i == IDX_SPI2_SEL ##1 1'b1 |=> spi_in_o.port2_slave_select_in == $past(pick_p2s))
    else $error("port2 select not following its new field");

  unimpl_zero_a: assert property ( // [RULE5]
    rd_i && (addr_i == IDX_SPI1_SEL || addr_i == IDX_SPI2_SEL || addr_i > IDX_LAST)
    |=> rdata_o[15:5] == 11'h000)
    else $error("unimplemented bits of single-field word read nonzero");

  gap_bits_a: assert property (rdata_o[15:13] == 3'h0 && rdata_o[7:5] == 3'h0) // [RULE5]
    else $error("gap bits of a word read nonzero");

  reset_value_a: assert property ( // [RULE6]
    !$past(resetn_i) && !$past(wr_i) |-> port1_select_source_field == IN_RST
    && port2_select_source_field == IN_RST && fld[F_OUT_BASE] == OUT_RST)
    else $error("field reset value wrong");

  pin0_route_a: assert property (remappable_pin_out_o[0] == $past(pick_pin0)) // [RULE7]
    else $error("pin 0 not driven by selected function");

  pin3_load_a: assert property ( // [RULE8]
    wr_i && addr_i == IDX_OUT_BASE + 4'h1 |=> fld[F_OUT_BASE + 3] == $past(wdata_i[12:8])
    ##1 remappable_pin_out_o[3] == $past(pick_pin3))
    else $error("pin 3 field or routing wrong after write");

  pin11_route_a: assert property (remappable_pin_out_o[11] == $past(pick_pin11)) // [RULE12]
    else $error("pin 11 not driven by selected function");

  fn_enable_a: assert property ( // [RULE9]
    wr_i && addr_i == IDX_OUT_BASE + 4'h2 && wdata_i[4:0] == FN_NONE
    |-> ##2 !remappable_pin_fn_en_o[4])
    else $error("pin 4 still claimed after code zero written");

  other_stable_a: assert property ( // [RULE10] [RULE14]
    wr_i && addr_i != IDX_OUT_BASE + 4'h3 |=> $stable(fld[F_OUT_BASE + 6]))
    else $error("pin 6 field changed by another write");

  readback_a: assert property ( // [RULE11] [RULE13]
    wr_i && addr_i == IDX_OUT_BASE + 4'h4 ##1 rd_i && addr_i == IDX_OUT_BASE + 4'h4
    |=> rdata_o == ($past(wdata_i, 2) & 16'h1f1f))
    else $error("pin 8/9 word read-back differs from write");

  p1_load_a: assert property ( // [RULE1]
    wr_i && addr_i == IDX_SPI1_SEL |=> port1_select_source_field == $past(wdata_i[4:0]))
    else $error("port1 select field not loaded from bits 4-0");

  p2_data_load_a: assert property ( // [RULE3]
    wr_i && addr_i == IDX_SPI2_CLK_DAT |=> port2_data_source_field == $past(wdata_i[4:0]))
    else $error("port2 data field not loaded from bits 4-0");

  p2_sel_load_a: assert property ( // [RULE4]
    wr_i && addr_i == IDX_SPI2_SEL |=> port2_select_source_field == $past(wdata_i[4:0]))
    else $error("port2 select field not loaded from bits 4-0");

  clk_data_reset_a: assert property ( // [RULE6]
    !$past(resetn_i) && !$past(wr_i) |-> port2_clock_source_field == IN_RST
    && port2_data_source_field == IN_RST && fld[F_OUT_BASE + 11] == OUT_RST)
    else $error("port2 clock/data or pin 11 field reset value wrong");

  field_hold_a: assert property ( // [RULE14]
    !wr_i |=> $stable(port1_select_source_field) && $stable(port2_select_source_field))
    else $error("select field changed with no write");

  read_idle_a: assert property (!rd_i |=> rdata_o == 16'h0000) // [RULE14]
    else $error("read data shown without a read strobe");

  pin1_route_a: assert property (remappable_pin_out_o[1] == $past(pick_pin1)) // [RULE7]
    else $error("pin 1 not driven by selected function");

  pin2_route_a: assert property (remappable_pin_out_o[2] == $past(pick_pin2)) // [RULE8]
    else $error("pin 2 not driven by selected function");

  pin4_route_a: assert property (remappable_pin_out_o[4] == $past(pick_pin4)) // [RULE9]
    else $error("pin 4 not driven by selected function");

  pin5_route_a: assert property (remappable_pin_out_o[5] == $past(pick_pin5)) // [RULE9]
    else $error("pin 5 not driven by selected function");

  pin6_route_a: assert property (remappable_pin_out_o[6] == $past(pick_pin6)) // [RULE10]
    else $error("pin 6 not driven by selected function");

  pin7_route_a: assert property (remappable_pin_out_o[7] == $past(pick_pin7)) // [RULE10]
    else $error("pin 7 not driven by selected function");

  pin8_route_a: assert property (remappable_pin_out_o[8] == $past(pick_pin8)) // [RULE11]
    else $error("pin 8 not driven by selected function");

  pin9_route_a: assert property (remappable_pin_out_o[9] == $past(pick_pin9)) // [RULE11]
    else $error("pin 9 not driven by selected function");

  pin10_route_a: assert property (remappable_pin_out_o[10] == $past(pick_pin10)) // [RULE12]
    else $error("pin 10 not driven by selected function");

  cov_write_read_c: cover property (wr_i && addr_i == IDX_SPI2_CLK_DAT ##1 rd_i && addr_i == IDX_SPI2_CLK_DAT);
  cov_pin_claim_c: cover property ($rose(remappable_pin_fn_en_o[0]));
  cov_unmapped_c: cover property (rd_i && addr_i > IDX_LAST);
  cov_spi_toggle_c: cover property ($changed(spi_in_o.port2_serial_clock_in));
  cov_code_zero_c: cover property ($fell(remappable_pin_fn_en_o[4]));

endmodule
`default_nettype wire

// ==== testbench/rpb_routing_bank_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module rpb_routing_bank_tb_top;
  import rpb_pkg::*;

  logic                clk_i;
  logic                resetn_i;
  logic [ADDR_W-1:0]   addr_i;
  logic [DATA_W-1:0]   wdata_i;
  logic                wr_i;
  logic                rd_i;
  logic [DATA_W-1:0]   rdata_o;
  logic [NUM_PINS-1:0] pins;
  logic [NUM_FN-1:0]   fns;
  rpb_spi_in_t         spi_in_o;
  logic [NUM_OUT-1:0]  pin_out;
  logic [NUM_OUT-1:0]  fn_en;
  int                  failures;
  int                  checks_done;
  int                  cycles;

  rpb_routing_bank dut (
    .clk_i                  (clk_i),
    .resetn_i               (resetn_i),
    .addr_i                 (addr_i),
    .wdata_i                (wdata_i),
    .wr_i                   (wr_i),
    .rd_i                   (rd_i),
    .rdata_o                (rdata_o),
    .remappable_pin_in_i    (pins),
    .periph_fn_out_i        (fns),
    .spi_in_o               (spi_in_o),
    .remappable_pin_out_o   (pin_out),
    .remappable_pin_fn_en_o (fn_en)
  );

  initial clk_i = 1'b0;
  always #2 clk_i = ~clk_i;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset();
    logic [DATA_W-1:0] d;
    @(posedge clk_i);
    resetn_i <= 1'b0;
    pins     <= 32'h0000_0000;
    fns      <= 32'h0000_0000;
    repeat (12) @(posedge clk_i);
    chk(32'({spi_in_o, pin_out}), 32'h0);
    chk(32'({fn_en, rdata_o}), 32'h0);
    resetn_i <= 1'b1;
    for (int i = 0; i < NUM_REGS; i++) begin
      bus_rd(ADDR_W'(i), d);
      chk(32'(d), (i == 1) ? 32'h1f1f : (i < 3) ? 32'h001f : 32'h0000);
    end
    chk(32'(fn_en), 32'h0);
    $display("test reset done");
  endtask

  task automatic test_masks();
    logic [DATA_W-1:0] d;
    for (int i = 0; i < 3; i++) begin
      bus_wr(ADDR_W'(i), 16'hffff);
      bus_rd(ADDR_W'(i), d);
      chk(32'(d), (i == 1) ? 32'h1f1f : 32'h001f);
    end
    // unmapped places take nothing and read zero
    bus_wr(4'h9, 16'hffff);
    bus_wr(4'hf, 16'h1234);
    bus_rd(4'h9, d);
    chk(32'(d), 32'h0);
    bus_rd(4'hf, d);
    chk(32'(d), 32'h0);
    $display("test masks done");
  endtask

  task automatic test_inputs();
    logic [NUM_PINS-1:0] v;
    bus_wr(IDX_SPI1_SEL, 16'hffe3);
    bus_wr(IDX_SPI2_CLK_DAT, 16'he7e9);
    bus_wr(IDX_SPI2_SEL, 16'h001e);
    for (int k = 0; k < 2; k++) begin
      v = (k == 0) ? 32'h0000_0088 : 32'hffff_ff77;
      @(posedge clk_i);
      pins <= v;
      settle();
      chk(32'(spi_in_o), 32'({v[3], v[7], v[9], v[30]}));
    end
    $display("test inputs done");
  endtask

  task automatic test_outputs();
    logic [DATA_W-1:0]  d;
    logic [NUM_FN-1:0]  pat;
    logic [NUM_OUT-1:0] exp;
    for (int j = 0; j < 6; j++) begin
      bus_wr(IDX_OUT_BASE + ADDR_W'(j), {3'h7, 5'(2 * j + 2), 3'h7, 5'(2 * j + 1)});
      bus_rd(IDX_OUT_BASE + ADDR_W'(j), d);
      chk(32'(d), 32'({3'h0, 5'(2 * j + 2), 3'h0, 5'(2 * j + 1)}));
    end
    // code 0 means no peripheral, so its function input stays low
    for (int k = 0; k < 2; k++) begin
      pat = (k == 0) ? 32'h0000_2aaa : 32'hffff_d554;
      @(posedge clk_i);
      fns <= pat;
      settle();
      for (int p = 0; p < NUM_OUT; p++) begin
        exp[p] = pat[p + 1];
      end
      chk(32'(pin_out), 32'(exp));
      chk(32'(fn_en), 32'hfff);
    end
    bus_wr(IDX_OUT_BASE, 16'h0200);
    settle();
    chk(32'({pin_out[0], fn_en}), 32'h0ffe);
    $display("test outputs done");
  endtask

  // write and read of one word with no idle cycle between the strobes
  task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w, output logic [DATA_W-1:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= w;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    rd_i    <= 1'b1;
    @(posedge clk_i);
    rd_i    <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic test_back_to_back();
    logic [DATA_W-1:0] d;
    wr_rd(IDX_SPI2_CLK_DAT, 16'h0a05, d);
    chk(32'(d), 32'h0a05);
    wr_rd(IDX_OUT_BASE + 4'h4, 16'h3ce6, d);
    chk(32'(d), 32'h1c06);
    @(posedge clk_i);
    fns <= 32'h0000_0400;
    // pin 4 gets code zero, pin 5 function 10
    wr_rd(IDX_OUT_BASE + 4'h2, 16'h0a00, d);
    settle();
    chk(32'({pin_out[5:4], fn_en[5:4]}), 32'ha);
    $display("test back to back done");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    failures    = 0;
    checks_done = 0;
    cycles      = 0;
    resetn_i    = 1'b0;
    addr_i      = 4'h0;
    wdata_i     = 16'h0000;
    wr_i        = 1'b0;
    rd_i        = 1'b0;
    pins        = 32'h0000_0000;
    fns         = 32'h0000_0000;
    test_reset();
    test_masks();
    test_inputs();
    test_outputs();
    test_back_to_back();
    test_reset();
    close_out();
  end
endmodule
`default_nettype wire
